// >>> rtl/rcb_pkg.sv
// constants, field positions and types of the radio command configuration bank
package rcb_pkg;
	// command register defaults
	localparam logic [15:0] CONFIG_RST = 16'h8008;
	localparam logic [15:0] POWER_RST  = 16'h8208;
	localparam logic [15:0] FREQ_RST   = 16'ha680;
	localparam logic [15:0] RATE_RST   = 16'hc623;
	localparam logic [15:0] RXCTL_RST  = 16'h9080;
	localparam logic [15:0] FILTER_RST = 16'hc22c;
	localparam logic [15:0] FIFO_RST   = 16'hca80;
	localparam logic [15:0] READ_CMD   = 16'hb000;

	// fixed command prefixes
	localparam logic [7:0] CONFIG_PFX = 8'h80;
	localparam logic [7:0] POWER_PFX  = 8'h82;
	localparam logic [3:0] FREQ_PFX   = 4'ha;
	localparam logic [7:0] RATE_PFX   = 8'hc6;
	localparam logic [4:0] RXCTL_PFX  = 5'h12;
	localparam logic [7:0] FILTER_PFX = 8'hc2;
	localparam logic [7:0] FIFO_PFX   = 8'hca;

	// field positions
	localparam int CFG_TXREG   = 7;
	localparam int CFG_FIFO    = 6;
	localparam int CFG_BAND_LO = 4;
	localparam int PWR_RX      = 7;
	localparam int PWR_BB      = 6;
	localparam int PWR_TX      = 5;
	localparam int PWR_SYNTH   = 4;
	localparam int PWR_XTAL    = 3;
	localparam int PWR_LBD     = 2;
	localparam int PWR_WAKE    = 1;
	localparam int PWR_CLKOFF  = 0;
	localparam int RATE_PRE    = 7;
	localparam int RXC_P20     = 10;
	localparam int RXC_SPD_LO  = 8;
	localparam int RXC_BW_LO   = 5;
	localparam int RXC_LNA_LO  = 3;
	localparam int FLT_AUTO    = 7;
	localparam int FLT_FAST    = 6;
	localparam int FLT_ANALOG  = 4;
	localparam int FIFO_LVL_LO = 4;
	localparam int FIFO_FILL   = 1;
	localparam int FIFO_SRST   = 0;

	// numeric constants
	localparam logic [11:0] FREQ_MIN       = 12'h060;
	localparam logic [11:0] FREQ_MAX       = 12'hf3f;
	localparam logic [15:0] RATE_BASE      = 16'h001d;
	localparam logic [15:0] SYNC_WORD      = 16'h2dd4;
	localparam logic [5:0]  XTAL_BASE_HPF  = 6'h11;
	localparam logic [7:0]  RSSI_BASE_DBM  = 8'h99;
	localparam logic [7:0]  RSSI_STEP_DB   = 8'h06;
	localparam logic [4:0]  CMD_BITS       = 5'h10;
	localparam logic [4:0]  PFX_BITS       = 5'h08;
	localparam logic [4:0]  FIFO_DEPTH     = 5'h10;
	localparam logic [4:0]  READ_BYTE      = 5'h08;
	localparam logic [1:0]  SPD_ALWAYS     = 2'h3;

	// write-only command registers as one carrier
	typedef struct packed {
		logic [15:0] config_w;
		logic [15:0] power_w;
		logic [15:0] freq_w;
		logic [15:0] rate_w;
		logic [15:0] rxctl_w;
		logic [15:0] filter_w;
		logic [15:0] fifo_w;
	} rcb_bank_t;

	localparam rcb_bank_t BANK_RST = '{CONFIG_RST, POWER_RST, FREQ_RST, RATE_RST,
		RXCTL_RST, FILTER_RST, FIFO_RST};

	// serial port states
	typedef enum logic [3:0] {
		SP_IDLE  = 4'h1,
		SP_SHIFT = 4'h2,
		SP_READ  = 4'h4,
		SP_OVER  = 4'h8
	} rcb_sp_state_t;
endpackage : rcb_pkg

// >>> rtl/rcb_sync2.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module rcb_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : rcb_sync2

// >>> rtl/rcb_cmd_bank.sv
// serial command interpreter and configuration bank of the radio transceiver
// Summary of operation
// - host shifts 16-bit commands MSB first, select low
// - one activates a function, except clkout_off and sensitive_reset_off; defaults at reset
// - configuration: txreg, fifo mode, band, crystal load
// - crystal load 8.5 pF plus 0.5 pF per code
// - fifo mode off: raw data and clock on pins
// - power command holds seven enable bits and clkout_off
// - tx chain powers synth and PA, starts transmit when txreg is set
// - clkout_off disables microcontroller clock buffer
// - frequency word kept unless within 96 to 3903
// - carrier from band constants C1, C2 and word
// - bit rate divider with prescale by eight
// - pin 20 interrupt input or valid flag output
// - valid flag speed, code 11 forces flag on
// - receiver bandwidth code, 000 and 111 reserved
// - amplifier gain 0, -6, -14, -20 dB
// - signal threshold -103 dBm step 6, plus gain
// - clock recovery auto lock or fixed fast/slow
// - analog filter disables clock recovery and FIFO
// - FIFO interrupt when bit count reaches level
// - fill only after sync word 2dd4 seen
// - sensitive_reset_off disables sensitive reset mode
// - read command returns eight FIFO bits
`timescale 1ns/1ps
module rcb_cmd_bank (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              select_n,
	input  wire logic              sck,
	input  wire logic              ser_in,
	output logic                   ser_out,
	input  wire logic              rx_data,
	input  wire logic              rx_bit_valid,
	input  wire logic              valid_raw,
	input  wire logic              cr_locked,
	input  wire logic              pin20_in,
	output logic                   pin20_out,
	output logic                   pin20_oe_n,
	output rcb_pkg::rcb_bank_t     cfg,
	output logic [5:0]             xtal_load_hpf,
	output logic [1:0]             band_c1,
	output logic [5:0]             band_c2,
	output logic                   bit_tick,
	output logic                   pa_synth_on,
	output logic                   tx_start,
	output logic                   clkout_en,
	output logic                   raw_rx_out,
	output logic                   raw_rx_clk_out,
	output logic                   valid_signal_flag,
	output logic                   ext_int_pulse,
	output logic                   cr_fast_mode,
	output logic                   bw_reserved,
	output logic signed [7:0]      rssi_set_level,
	output logic                   fifo_irq,
	output logic                   fifo_synced,
	output logic                   sensitive_reset_en
);
	// prefix decode: index 0..6 of the bank, 7 for no match
	function automatic logic [2:0] cmd_index(input logic [15:0] w);
		if (w[15:8] == rcb_pkg::CONFIG_PFX)
			return 3'h0;
		else if (w[15:8] == rcb_pkg::POWER_PFX)
			return 3'h1;
		else if (w[15:12] == rcb_pkg::FREQ_PFX)
			return 3'h2;
		else if (w[15:8] == rcb_pkg::RATE_PFX)
			return 3'h3;
		else if (w[15:11] == rcb_pkg::RXCTL_PFX)
			return 3'h4;
		else if (w[15:8] == rcb_pkg::FILTER_PFX)
			return 3'h5;
		else if (w[15:8] == rcb_pkg::FIFO_PFX)
			return 3'h6;
		return 3'h7;
	endfunction : cmd_index

	// amplifier attenuation in dB
	function automatic logic [7:0] lna_gain(input logic [1:0] code);
		case (code)
			2'h0:    return 8'h00;
			2'h1:    return 8'hfa;
			2'h2:    return 8'hf2;
			default: return 8'hec;
		endcase
	endfunction : lna_gain

	logic [3:0]              pin_q;
	logic                    sel_n_s;
	logic                    sck_s;
	logic                    sdi_s;
	logic                    int_s;
	logic                    sck_d;
	logic                    sel_d;
	logic                    int_d;
	rcb_pkg::rcb_sp_state_t  state;
	rcb_pkg::rcb_sp_state_t  next_state;
	logic [15:0]             shreg;
	logic [4:0]              bitcnt;
	logic [7:0]              out_byte;
	logic [15:0]             fifo;
	logic [4:0]              fifo_cnt;
	logic [15:0]             sync_sh;
	logic                    synced;
	logic [15:0]             rate_cnt;
	logic                    cr_lock_seen;

	// pins from the host cross into the clock domain first
	rcb_sync2 #(.W(4)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({select_n, sck, ser_in, pin20_in}),
		.q      (pin_q)
	);
	assign {sel_n_s, sck_s, sdi_s, int_s} = pin_q;

	// edge detection on synchronised pins
	wire sck_rise  = sck_s & ~sck_d & ~sel_n_s;
	wire sel_rise  = sel_n_s & ~sel_d;
	wire int_fall  = ~int_s & int_d;
	wire [15:0] next_shreg = {shreg[14:0], sdi_s};
	wire full_cmd  = (bitcnt >= rcb_pkg::CMD_BITS);
	wire [2:0] widx = cmd_index(shreg);
	wire do_write  = sel_rise & full_cmd & (state != rcb_pkg::SP_READ);

	// field views of the bank
	wire       txreg_on       = cfg.config_w[rcb_pkg::CFG_TXREG];
	wire       fifo_mode_on   = cfg.config_w[rcb_pkg::CFG_FIFO];
	wire [1:0] band_select    = cfg.config_w[rcb_pkg::CFG_BAND_LO +: 2];
	wire [3:0] xtal_load_code = cfg.config_w[3:0];
	wire       tx_chain_on    = cfg.power_w[rcb_pkg::PWR_TX];
	wire       clkout_off     = cfg.power_w[rcb_pkg::PWR_CLKOFF];
	wire       prescale_by8   = cfg.rate_w[rcb_pkg::RATE_PRE];
	wire [6:0] rate_r         = cfg.rate_w[6:0];
	wire       pin_func_sel   = cfg.rxctl_w[rcb_pkg::RXC_P20];
	wire [1:0] valid_flag_speed = cfg.rxctl_w[rcb_pkg::RXC_SPD_LO +: 2];
	wire [2:0] rx_bw_code     = cfg.rxctl_w[rcb_pkg::RXC_BW_LO +: 3];
	wire [1:0] lna_atten_code = cfg.rxctl_w[rcb_pkg::RXC_LNA_LO +: 2];
	wire [2:0] rssi_thresh_code = cfg.rxctl_w[2:0];
	wire       cr_auto_lock   = cfg.filter_w[rcb_pkg::FLT_AUTO];
	wire       cr_fast_sel    = cfg.filter_w[rcb_pkg::FLT_FAST];
	wire       filter_analog  = cfg.filter_w[rcb_pkg::FLT_ANALOG];
	wire [3:0] fill_irq_level = cfg.fifo_w[rcb_pkg::FIFO_LVL_LO +: 4];
	wire       sync_fill_on   = cfg.fifo_w[rcb_pkg::FIFO_FILL];
	wire       sensitive_reset_off = cfg.fifo_w[rcb_pkg::FIFO_SRST];

	// frequency word only taken within its legal range
	wire [11:0] freq_word = shreg[11:0];
	wire freq_ok = (freq_word >= rcb_pkg::FREQ_MIN) && (freq_word <= rcb_pkg::FREQ_MAX);

	// fifo path usable only in fifo mode with digital filtering
	wire fifo_path = fifo_mode_on & ~filter_analog;
	wire [15:0] next_sync = {sync_sh[14:0], rx_data};
	wire sync_hit  = rx_bit_valid & fifo_path & sync_fill_on & (next_sync == rcb_pkg::SYNC_WORD);
	wire push      = rx_bit_valid & fifo_path & sync_fill_on & synced;
	wire full_fifo = (fifo_cnt == rcb_pkg::FIFO_DEPTH);
	wire push_ok   = push & ~full_fifo;
	wire have_byte = (fifo_cnt >= rcb_pkg::READ_BYTE);
	wire read_hit  = sck_rise & (state == rcb_pkg::SP_SHIFT) & (bitcnt == rcb_pkg::PFX_BITS - 5'h01)
		& (next_shreg[7:0] == rcb_pkg::READ_CMD[15:8]) & fifo_mode_on;
	wire pop       = read_hit & have_byte;
	wire [4:0] oldest_sh = fifo_cnt - rcb_pkg::READ_BYTE;
	wire [15:0] fifo_aligned = fifo >> oldest_sh;
	wire [7:0] pop_byte = have_byte ? fifo_aligned[7:0] : 8'h00;
	wire [4:0] cnt_after_pop = pop ? oldest_sh : fifo_cnt;
	wire [15:0] fifo_masked = fifo & ((16'h0001 << cnt_after_pop) - 16'h0001);
	wire [4:0] next_fifo_cnt = cnt_after_pop + {4'h0, push_ok};
	wire [15:0] next_fifo = push_ok ? {fifo_masked[14:0], rx_data} : fifo_masked;

	// bit-rate period in system cycles at 10 MHz
	// r+1 kept at eight bits so the largest divider does not wrap to zero
	wire [15:0] rate_div  = rcb_pkg::RATE_BASE * {8'h00, {1'b0, rate_r} + 8'h01};
	wire [15:0] rate_len  = prescale_by8 ? {rate_div[12:0], 3'h0} : rate_div;
	wire [15:0] rate_last = rate_len - 16'h0001;

	// signal-strength threshold plus gain
	wire [7:0] rssi_step = rcb_pkg::RSSI_STEP_DB * {5'h00, rssi_thresh_code};
	wire [7:0] rssi_sum  = rcb_pkg::RSSI_BASE_DBM + rssi_step + lna_gain(lna_atten_code);

	// band constants C1 and C2
	wire [1:0] c1_sel = (band_select == 2'h3) ? 2'h3 : ((band_select == 2'h2) ? 2'h2 : 2'h1);
	wire [5:0] c2_sel = (band_select == 2'h0) ? 6'h1f : ((band_select == 2'h3) ? 6'h1e : 6'h2b);

	// serial port sequencing; select high reinitialises
	always_comb begin
		next_state = state;
		case (state)
			rcb_pkg::SP_IDLE:
				if (!sel_n_s)
					next_state = rcb_pkg::SP_SHIFT;
			rcb_pkg::SP_SHIFT:
				if (sel_n_s)
					next_state = rcb_pkg::SP_IDLE;
				else if (read_hit)
					next_state = rcb_pkg::SP_READ;
				else if (sck_rise && bitcnt == rcb_pkg::CMD_BITS - 5'h01)
					next_state = rcb_pkg::SP_OVER;
			rcb_pkg::SP_READ:
				if (sel_n_s)
					next_state = rcb_pkg::SP_IDLE;
			rcb_pkg::SP_OVER:
				if (sel_n_s)
					next_state = rcb_pkg::SP_IDLE;
			default:
				next_state = rcb_pkg::SP_IDLE;
		endcase
	end

	// edge history and state
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sck_d <= 1'b1;  // matches the synchroniser's reset level, no false rise
			sel_d <= 1'b1;
			int_d <= 1'b1;
			state <= rcb_pkg::SP_IDLE;
		end else begin
			sck_d <= sck_s;
			sel_d <= sel_n_s;
			int_d <= int_s;
			state <= next_state;
		end
	end

	// shift in MSB first, first 16 bits kept
	always_ff @(posedge clk) begin
		if (!resetn || sel_n_s) begin
			shreg  <= 16'h0000;
			bitcnt <= 5'h00;
		end else if (sck_rise && !full_cmd) begin
			shreg  <= next_shreg;
			bitcnt <= bitcnt + 5'h01;
		end
	end

	// read data: loaded after the prefix, shifted on each rise
	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_byte <= 8'h00;
			ser_out  <= 1'b0;
		end else if (read_hit) begin
			out_byte <= {pop_byte[6:0], 1'b0};
			ser_out  <= pop_byte[7];
		end else if (sck_rise && state == rcb_pkg::SP_READ) begin
			out_byte <= {out_byte[6:0], 1'b0};
			ser_out  <= out_byte[7];
		end
	end

	// command bank written on select rise by prefix
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg <= rcb_pkg::BANK_RST;
		end else if (do_write) begin
			case (widx)
				3'h0:    cfg.config_w <= shreg;
				3'h1:    cfg.power_w  <= shreg;
				3'h2:    if (freq_ok) cfg.freq_w <= shreg;
				3'h3:    cfg.rate_w   <= shreg;
				3'h4:    cfg.rxctl_w  <= shreg;
				3'h5:    cfg.filter_w <= shreg;
				3'h6:    cfg.fifo_w   <= shreg;
				default: cfg <= cfg;
			endcase
		end
	end

	// receive fifo and sync recognition
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fifo     <= 16'h0000;
			fifo_cnt <= 5'h00;
			sync_sh  <= 16'h0000;
			synced   <= 1'b0;
		end else begin
			fifo     <= next_fifo;
			fifo_cnt <= next_fifo_cnt;
			if (rx_bit_valid)
				sync_sh <= next_sync;
			if (!sync_fill_on)
				synced <= 1'b0;
			else if (sync_hit)
				synced <= 1'b1;
		end
	end

	// bit-rate enable divider
	always_ff @(posedge clk) begin
		if (!resetn || rate_cnt >= rate_last) begin
			rate_cnt <= 16'h0000;
		end else begin
			rate_cnt <= rate_cnt + 16'h0001;
		end
	end

	// lock history for auto clock recovery, cleared when locking lost
	always_ff @(posedge clk) begin
		if (!resetn)
			cr_lock_seen <= 1'b0;
		else
			cr_lock_seen <= cr_locked;
	end

	// registered derived outputs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			xtal_load_hpf      <= rcb_pkg::XTAL_BASE_HPF;
			band_c1            <= 2'h1;
			band_c2            <= 6'h1f;
			bit_tick           <= 1'b0;
			pa_synth_on        <= 1'b0;
			tx_start           <= 1'b0;
			clkout_en          <= 1'b1;
			raw_rx_out         <= 1'b0;
			raw_rx_clk_out     <= 1'b0;
			valid_signal_flag  <= 1'b0;
			ext_int_pulse      <= 1'b0;
			cr_fast_mode       <= 1'b1;
			bw_reserved        <= 1'b0;
			rssi_set_level     <= 8'sh99;
			fifo_irq           <= 1'b0;
			fifo_synced        <= 1'b0;
			sensitive_reset_en <= 1'b1;
			pin20_out          <= 1'b0;
			pin20_oe_n         <= 1'b1;
		end else begin
			xtal_load_hpf      <= rcb_pkg::XTAL_BASE_HPF + {2'h0, xtal_load_code};
			band_c1            <= c1_sel;
			band_c2            <= c2_sel;
			bit_tick           <= (rate_cnt >= rate_last);
			pa_synth_on        <= tx_chain_on;
			tx_start           <= tx_chain_on & txreg_on;
			clkout_en          <= ~clkout_off;
			raw_rx_out         <= fifo_mode_on ? 1'b0 : rx_data;
			raw_rx_clk_out     <= fifo_mode_on ? 1'b0 : rx_bit_valid;
			valid_signal_flag  <= (valid_flag_speed == rcb_pkg::SPD_ALWAYS) | valid_raw;
			ext_int_pulse      <= int_fall & ~pin_func_sel;
			cr_fast_mode       <= ~filter_analog & (cr_auto_lock ? ~cr_lock_seen : cr_fast_sel);
			bw_reserved        <= (rx_bw_code == 3'h0) | (rx_bw_code == 3'h7);
			rssi_set_level     <= rssi_sum;
			fifo_irq           <= fifo_path & (fifo_cnt >= {1'b0, fill_irq_level});
			fifo_synced        <= synced;
			sensitive_reset_en <= ~sensitive_reset_off;
			pin20_out          <= (valid_flag_speed == rcb_pkg::SPD_ALWAYS) | valid_raw;
			pin20_oe_n         <= ~pin_func_sel;
		end
	end
endmodule : rcb_cmd_bank

// >>> dv/rcb_cmd_bank_sva.sv
// port assertions for the radio command configuration bank
`timescale 1ns/1ps
module rcb_cmd_bank_sva (
	input wire logic               clk,
	input wire logic               resetn,
	input wire logic               select_n,
	input wire logic               rx_data,
	input wire logic               rx_bit_valid,
	input wire logic               cr_locked,
	input wire rcb_pkg::rcb_bank_t cfg,
	input wire logic               pin20_oe_n,
	input wire logic               clkout_en,
	input wire logic               raw_rx_out,
	input wire logic               raw_rx_clk_out,
	input wire logic               valid_signal_flag,
	input wire logic               ext_int_pulse,
	input wire logic               cr_fast_mode,
	input wire logic               fifo_synced
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// words only move after select has been high a while
	property p_cmd;
		!$stable(cfg) |-> select_n && $past(select_n, 2);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command word moved during a frame");

	// out-of-range words never land
	property p_freq;
		!$stable(cfg.freq_w) |-> cfg.freq_w[11:0] >= 12'h060 && cfg.freq_w[11:0] <= 12'hf3f;
	endproperty
	a_freq: assert property (p_freq) else $error("frequency word outside range");

	property p_clk;
		clkout_en == !$past(cfg.power_w[0]);
	endproperty
	a_clk: assert property (p_clk) else $error("clock output buffer wrong");

	property p_oe;
		pin20_oe_n == !$past(cfg.rxctl_w[10]);
	endproperty
	a_oe: assert property (p_oe) else $error("pin 20 direction wrong");

	// raw pins follow the demodulator one clock late with the fifo off
	property p_raw;
		$stable(cfg.config_w[6]) && !cfg.config_w[6] |=>
			raw_rx_out == $past(rx_data) && raw_rx_clk_out == $past(rx_bit_valid);
	endproperty
	a_raw: assert property (p_raw) else $error("raw data pins wrong");

	property p_ext;
		ext_int_pulse |-> !$past(cfg.rxctl_w[10]) ##1 !ext_int_pulse;
	endproperty
	a_ext: assert property (p_ext) else $error("interrupt input pulse wrong");

	property p_vsf;
		cfg.rxctl_w[9:8] == 2'h3 |=> valid_signal_flag;
	endproperty
	a_vsf: assert property (p_vsf) else $error("valid flag not forced");

	property p_cr;
		cfg.filter_w[4] |=> !cr_fast_mode;
	endproperty
	a_cr: assert property (p_cr) else $error("recovery active with analog filter");

	// auto lock: lock history one clock, output one more
	property p_cr_auto;
		cfg.filter_w[7] && !cfg.filter_w[4] |=> cr_fast_mode == !$past(cr_locked, 2);
	endproperty
	a_cr_auto: assert property (p_cr_auto) else $error("auto lock recovery mode wrong");

	// synced flag clears one clock after the bit, the output one more
	property p_sync;
		!cfg.fifo_w[1] |-> ##2 !fifo_synced;
	endproperty
	a_sync: assert property (p_sync) else $error("fill kept after clear");

	c_cmd: cover property (!$stable(cfg));
	c_ext: cover property (ext_int_pulse);
	c_sync: cover property ($rose(fifo_synced));
endmodule : rcb_cmd_bank_sva

bind rcb_cmd_bank rcb_cmd_bank_sva u_rcb_cmd_bank_sva (
	.clk(clk), .resetn(resetn), .select_n(select_n), .rx_data(rx_data), .rx_bit_valid(rx_bit_valid),
	.cr_locked(cr_locked),
	.cfg(cfg), .pin20_oe_n(pin20_oe_n), .clkout_en(clkout_en), .raw_rx_out(raw_rx_out),
	.raw_rx_clk_out(raw_rx_clk_out), .valid_signal_flag(valid_signal_flag),
	.ext_int_pulse(ext_int_pulse), .cr_fast_mode(cr_fast_mode), .fifo_synced(fifo_synced)
);

// >>> dv/rcb_host_model.sv
// host controller model driving the serial command port
`timescale 1ns/1ps
module rcb_host_model (
	input  wire logic clk,
	output logic      select_n,
	output logic      sck,
	output logic      ser_in,
	input  wire logic ser_out
);
	// link clock idles low between frames
	initial begin
		select_n = 1'b1;
		sck      = 1'b0;
		ser_in   = 1'b0;
	end

	// half of the 800 ns link period
	task automatic half();
		repeat (4) @(negedge clk);
	endtask : half

	// n bits msb first; answer bits taken just before rises 9 to 16
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		select_n = 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			ser_in = w[15-i];
			half();
			if (i >= 8) rd = {rd[6:0], ser_out};
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
		half();
		select_n = 1'b1;
		ser_in = ~ser_in; // released line must not look held
		repeat (4) half();
	endtask : xfer
endmodule : rcb_host_model

// >>> dv/testbench.sv
// self-checking bench for the radio command configuration bank
`timescale 1ns/1ps
module testbench;
	logic clk, resetn, select_n, sck, ser_in, ser_out, rx_data, rx_bit_valid, valid_raw, cr_locked;
	logic pin20_in, pin20_out, pin20_oe_n, bit_tick, pa_synth_on, tx_start, clkout_en, raw_rx_out;
	logic raw_rx_clk_out, valid_signal_flag, ext_int_pulse, cr_fast_mode, bw_reserved, fifo_irq;
	logic fifo_synced, sensitive_reset_en, synced;
	logic [5:0]         xtal_load_hpf, band_c2;
	logic [1:0]         band_c1;
	logic signed [7:0]  rssi_set_level;
	rcb_pkg::rcb_bank_t cfg;
	int                 n_errors, compares, cycles, s;
	integer             seed = 16953;
	logic [15:0]        w, sync_sh;
	logic [15:0]        exp_w [7];
	logic [15:0]        pfx [7] = '{16'h8000, 16'h8200, 16'ha000, 16'hc600, 16'h9000, 16'hc200, 16'hca00};
	logic [15:0]        fm [7] = '{16'hff00, 16'hff00, 16'hf000, 16'hff80, 16'hf800, 16'hff04, 16'hff00};
	logic [11:0]        fb [4] = '{12'h05f, 12'h060, 12'hf3f, 12'hf40};
	logic               q [$];

	rcb_cmd_bank u_rcb_cmd_bank (.clk(clk), .resetn(resetn), .select_n(select_n), .sck(sck),
		.ser_in(ser_in), .ser_out(ser_out), .rx_data(rx_data), .rx_bit_valid(rx_bit_valid),
		.valid_raw(valid_raw), .cr_locked(cr_locked), .pin20_in(pin20_in), .pin20_out(pin20_out),
		.pin20_oe_n(pin20_oe_n), .cfg(cfg), .xtal_load_hpf(xtal_load_hpf), .band_c1(band_c1),
		.band_c2(band_c2), .bit_tick(bit_tick), .pa_synth_on(pa_synth_on), .tx_start(tx_start),
		.clkout_en(clkout_en), .raw_rx_out(raw_rx_out), .raw_rx_clk_out(raw_rx_clk_out),
		.valid_signal_flag(valid_signal_flag), .ext_int_pulse(ext_int_pulse),
		.cr_fast_mode(cr_fast_mode), .bw_reserved(bw_reserved), .rssi_set_level(rssi_set_level),
		.fifo_irq(fifo_irq), .fifo_synced(fifo_synced), .sensitive_reset_en(sensitive_reset_en));
	rcb_host_model u_rcb_host_model (.clk(clk), .select_n(select_n), .sck(sck), .ser_in(ser_in),
		.ser_out(ser_out));

	always #50 clk = ~clk;

	// hang guard, well above the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			$display("MISMATCH t=%0t timeout", $time);
			test_done();
		end
	end

	// free-running analog inputs and interrupt pin
	always @(negedge clk) begin
		{valid_raw, cr_locked, pin20_in} <= 3'($random(seed));
	end

	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask : check

	function automatic int slot(input logic [15:0] c);
		case (c[15:8])
			8'h80: return 0;
			8'h82: return 1;
			8'hc6: return 3;
			8'hc2: return 5;
			8'hca: return 6;
			default: ;
		endcase
		if (c[15:12] == 4'ha) return 2;
		if (c[15:11] == 5'h12) return 4;
		return -1;
	endfunction : slot

	// one frame; the bank model takes complete, accepted words only
	task automatic wr(input logic [15:0] c, input int n);
		logic [7:0] rd;
		int k;
		k = slot(c);
		u_rcb_host_model.xfer(c, n, rd);
		if (n == 16 && k >= 0 && (k != 2 || (c[11:0] >= 12'h060 && c[11:0] <= 12'hf3f))) exp_w[k] = c;
		if (exp_w[6][1] === 1'b0) synced = 1'b0;
	endtask : wr

	task automatic chk();
		logic [15:0] c, p, r;
		int c1 [4] = '{1, 1, 2, 3};
		int c2 [4] = '{31, 43, 43, 30};
		int g [4] = '{0, -6, -14, -20};
		c = exp_w[0];
		p = exp_w[1];
		r = exp_w[4];
		for (int i = 0; i < 7; i++) check(cfg[111-16*i -: 16] === exp_w[i], "command word");
		check(xtal_load_hpf === 6'(17 + c[3:0]), "crystal load");
		check(band_c1 === 2'(c1[c[5:4]]) && band_c2 === 6'(c2[c[5:4]]), "band constants");
		check(rssi_set_level === 8'(g[r[4:3]] - 103 + 6 * r[2:0]), "threshold");
		check(bw_reserved === (r[7:5] == 3'h0 || r[7:5] == 3'h7), "bandwidth code");
		check(pin20_oe_n === ~r[10], "pin 20 direction");
		check(pa_synth_on === p[5] && tx_start === (p[5] & c[7]), "transmit chain");
		check(clkout_en === ~p[0] && sensitive_reset_en === ~exp_w[6][0], "inverted enables");
	endtask : chk

	// one received bit; model fills only after the pattern
	task automatic feed(input logic b);
		rx_data = b;
		rx_bit_valid = 1'b1;
		@(negedge clk);
		rx_bit_valid = 1'b0;
		repeat (3) @(negedge clk);
		if (synced && exp_w[6][1] && q.size() < 16) q.push_back(b);
		sync_sh = {sync_sh[14:0], b};
		if (exp_w[6][1] && sync_sh == 16'h2dd4) synced = 1'b1;
	endtask : feed

	task automatic rdf();
		logic [7:0] d, e;
		e = 8'h00;
		if (q.size() >= 8)
			for (int i = 0; i < 8; i++) e = {e[6:0], q.pop_front()};
		u_rcb_host_model.xfer(16'hb000, 16, d);
		check(d === e, "fifo read");
	endtask : rdf

	// skip two ticks so an old count drains, then time one period
	task automatic gap(input int want);
		int n;
		n = 1;
		repeat (2) begin
			@(negedge clk);
			while (bit_tick !== 1'b1) @(negedge clk);
		end
		@(negedge clk);
		while (bit_tick !== 1'b1) begin
			n++;
			@(negedge clk);
		end
		check(n == want, "bit_tick period");
	endtask : gap

	task automatic test_done();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		rx_data = 1'b0;
		rx_bit_valid = 1'b0;
		{valid_raw, cr_locked, pin20_in} = 3'h0;
		n_errors = 0;
		compares = 0;
		cycles = 0;
		synced = 1'b0;
		sync_sh = 16'h0000;
		exp_w = '{16'h8008, 16'h8208, 16'ha680, 16'hc623, 16'h9080, 16'hc22c, 16'hca80};
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		chk();
		$display("test defaults done");
		// every command word, random fields
		for (int k = 0; k < 35; k++) begin
			s = k % 7;
			w = pfx[s] | (16'($random(seed)) & ~fm[s]);
			wr(w, 16);
			chk();
		end
		foreach (fb[i]) begin
			wr({4'ha, fb[i]}, 16);
			chk();
		end
		$display("test writes done");
		// short frame, unknown prefix and read with fifo off
		wr(16'h8008, 16);
		wr(16'h82ff, 8);
		wr(16'hc4f7, 16);
		wr(16'hb000, 16);
		chk();
		$display("test refusals done");
		wr(16'h8048, 16);
		wr(16'hc22b, 16);
		wr(16'hca80, 16);
		wr(16'hca83, 16);
		for (int i = 23; i >= 0; i--) feed(1'(24'haa2dd4 >> i));
		check(fifo_synced === 1'b1, "pattern seen");
		repeat (7) feed(1'($random(seed)));
		check(fifo_irq === 1'b0, "fifo level early");
		repeat (9) feed(1'($random(seed)));
		check(fifo_irq === 1'b1, "fifo level reached");
		rdf();
		rdf();
		check(fifo_irq === 1'b0, "fifo level after drain");
		rdf();
		wr(16'hca81, 16);
		check(fifo_synced === 1'b0, "fill stopped");
		$display("test fifo done");
		wr(16'h8008, 16);
		repeat (8) feed(1'($random(seed)));
		wr(16'h9700, 16);
		check(valid_signal_flag === 1'b1 && pin20_out === 1'b1 && pin20_oe_n === 1'b0, "valid flag");
		$display("test pins done");
		wr(16'hc601, 16);
		gap(58);
		wr(16'hc681, 16);
		gap(464);
		// largest divider, r+1 must not wrap
		wr(16'hc67f, 16);
		gap(3712);
		$display("test rate done");
		test_done();
	end
endmodule : testbench
